// >>> src/dmhp_defines.vh
`ifndef DMHP_DEFINES_VH
`define DMHP_DEFINES_VH
`define DMHP_ADDR_W 6
`define DMHP_DATA_W 8
`define DMHP_NUM_REGS 64
`define DMHP_CLK_PERIOD_NS 10
`define DMHP_RD_VALID_NS 96
`define DMHP_RD_VALID_CYC (`DMHP_RD_VALID_NS / `DMHP_CLK_PERIOD_NS)
`define DMHP_RELEASE_NS 10
`define DMHP_RELEASE_CYC (`DMHP_RELEASE_NS / `DMHP_CLK_PERIOD_NS)
`define DMHP_STYLE_STROBE 1'b0
`define DMHP_STYLE_SEPARATE 1'b1
`define DMHP_REG_RESET 8'h00
`endif

// >>> src/dmhp_sync.v
`timescale 1ns/100ps
// two-flop synchroniser, reset to the idle (high) level
module dmhp_sync (
    input wire clk_sys,
    input wire rst,
    input wire d,
    output wire q
);
    reg s1_q;
    reg s2_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end
    assign q = s2_q;
endmodule // dmhp_sync

// >>> src/dmhp_port.v
`timescale 1ns/100ps
`include "dmhp_defines.vh"
// Behaviour
// RULE_01 - host: address, select, then write strobe
// RULE_02 - ready low once write can be accepted
// RULE_03 - capture write data on strobe rising edge
// RULE_04 - host without handshake holds strobe 120 ns
// RULE_05 - host: address, select, then read strobe
// RULE_06 - drive read data, then ready low; code drives data and ready low in the same cycle
// RULE_07 - host samples read data at strobe rise
// RULE_08 - read data valid within 96 ns
// RULE_09 - release bus and ready after read
// RULE_10 - host: read/write low marks strobe-style write
// RULE_11 - acknowledge low when write data accepted
// RULE_12 - host: read/write high marks strobe-style read
// RULE_13 - read data and acknowledge driven together
// RULE_14 - host samples data at strobe rise
// RULE_15 - host without acknowledge holds strobe 120 ns
// RULE_16 - release acknowledge and bus after strobe rise
// RULE_17 - strap picks bus style, low strobe style
// RULE_18 - six-bit address, eight-bit data, bit7 msb
// RULE_19 - deselected: ignore strobes, outputs released
// RULE_20 - synchronise strobes, one write per pulse
module dmhp_port (
    input wire clk_sys,
    input wire rst,
    input wire bus_style_select,
    input wire sel_n,
    input wire [`DMHP_ADDR_W-1:0] reg_addr,
    input wire wr_strobe_n,
    input wire rd_strobe_n,
    input wire [`DMHP_DATA_W-1:0] host_data_i,
    output wire [`DMHP_DATA_W-1:0] host_data_o,
    output wire host_data_oe,
    output wire transfer_ack_n_o,
    output wire transfer_ack_n_oe,
    output wire [`DMHP_DATA_W-1:0] reg_rd_probe
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ACT = 2'h1;
    localparam ST_DONE = 2'h2;

    // strap is static; caught once after reset release
    reg style_q;
    reg style_valid_q;
    wire sel_s;
    wire pin86_s;
    wire pin85_s;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg is_read_q;
    reg [`DMHP_ADDR_W-1:0] addr_q;
    reg [`DMHP_DATA_W-1:0] dout_q;
    reg data_oe_q;
    reg ack_q;
    reg [`DMHP_DATA_W-1:0] regs [0:`DMHP_NUM_REGS-1];
    reg [`DMHP_DATA_W-1:0] wdata_q;
    integer i;

    dmhp_sync u_sel (.clk_sys(clk_sys), .rst(rst), .d(sel_n), .q(sel_s));
    dmhp_sync u_p86 (.clk_sys(clk_sys), .rst(rst), .d(wr_strobe_n), .q(pin86_s));
    dmhp_sync u_p85 (.clk_sys(clk_sys), .rst(rst), .d(rd_strobe_n), .q(pin85_s));

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            style_q <= `DMHP_STYLE_SEPARATE;
            style_valid_q <= 1'b0;
        end else if (!style_valid_q) begin
            style_q <= bus_style_select; // RULE_17
            style_valid_q <= 1'b1;
        end
    end

    // decode: separate style uses pin86 as write, pin85 as read;
    // strobe style uses pin86 as strobe, pin85 as read/write

    // write request for the selected style
    function wr_req_f;
        input sep_f;
        input p86_f;
        input p85_f;
        begin
            if (sep_f) begin
                // both strobes low is illegal, so read strobe must be idle
                wr_req_f = !p86_f && p85_f;
            end else begin
                wr_req_f = !p86_f && !p85_f;
            end
        end
    endfunction

    // read request for the selected style
    function rd_req_f;
        input sep_f;
        input p86_f;
        input p85_f;
        begin
            if (sep_f) begin
                rd_req_f = !p85_f && p86_f;
            end else begin
                rd_req_f = !p86_f && p85_f;
            end
        end
    endfunction

    // any strobe still held; read/write level alone is not a strobe
    function strobe_on_f;
        input sep_f;
        input p86_f;
        input p85_f;
        begin
            if (sep_f) begin
                strobe_on_f = !p86_f || !p85_f;
            end else begin
                strobe_on_f = !p86_f;
            end
        end
    endfunction

    wire sep = (style_q == `DMHP_STYLE_SEPARATE);
    wire wr_req = wr_req_f(sep, pin86_s, pin85_s);
    wire rd_req = rd_req_f(sep, pin86_s, pin85_s);
    wire strobe_on = strobe_on_f(sep, pin86_s, pin85_s);
    wire start = style_valid_q && !sel_s && (wr_req || rd_req); // RULE_19

    // synchronised strobe rise ends the access
    wire end_access = (state_q == ST_ACT) && !strobe_on;

    // select dropped with the strobe still low: abandon, no write
    wire abort_access = (state_q == ST_ACT) && strobe_on && sel_s; // RULE_19

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_ACT;
                end
            end
            ST_ACT: begin
                // rising strobe ends the access
                if (!strobe_on) begin
                    state_d = ST_DONE;
                end else if (sel_s) begin
                    // otherwise a host that walks away would hold the bus forever
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            is_read_q <= 1'b0;
            addr_q <= {`DMHP_ADDR_W{1'b0}};
            dout_q <= `DMHP_REG_RESET;
            data_oe_q <= 1'b0;
            ack_q <= 1'b0;
            wdata_q <= `DMHP_REG_RESET;
        end else begin
            state_q <= state_d;
            // track live data while strobe is low; last value before rise wins
            wdata_q <= host_data_i;
            if (state_q == ST_IDLE && start) begin
                is_read_q <= rd_req;
                addr_q <= reg_addr; // RULE_18
                ack_q <= 1'b1; // RULE_02 RULE_11
                if (rd_req) begin
                    dout_q <= regs[reg_addr]; // RULE_06 RULE_13
                    data_oe_q <= 1'b1; // RULE_08
                end
            end else if (end_access) begin
                ack_q <= 1'b0; // RULE_09 RULE_16
                data_oe_q <= 1'b0; // RULE_09 RULE_16
            end else if (abort_access) begin
                // let go of the pins at once, nothing is written
                ack_q <= 1'b0; // RULE_19
                data_oe_q <= 1'b0; // RULE_19
            end
        end
    end

    // data held in a two-deep pipe so the pre-rise sample is used
    reg [`DMHP_DATA_W-1:0] wdata_prev_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdata_prev_q <= `DMHP_REG_RESET;
        end else begin
            wdata_prev_q <= wdata_q;
        end
    end

    // write once per pulse, at the synchronised rising edge
    // one cycle in ACT only, so a long strobe still writes once
    wire do_write = end_access && !is_read_q; // RULE_03 RULE_20

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (i = 0; i < `DMHP_NUM_REGS; i = i + 1) begin
                regs[i] <= `DMHP_REG_RESET;
            end
        end else if (do_write) begin
            regs[addr_q] <= wdata_prev_q; // RULE_03
        end
    end

    assign host_data_o = dout_q;
    assign host_data_oe = data_oe_q; // RULE_19
    assign transfer_ack_n_o = ~ack_q;
    assign transfer_ack_n_oe = ack_q; // RULE_19
    assign reg_rd_probe = regs[addr_q];
endmodule // dmhp_port

// >>> test/dmhp_port_asserts.sv
`timescale 1ns/100ps
`include "dmhp_defines.vh"
module dmhp_port_asserts (
    input logic clk_sys, rst, bus_style_select, sel_n, wr_strobe_n, rd_strobe_n,
    input logic [`DMHP_DATA_W-1:0] host_data_o, reg_rd_probe,
    input logic host_data_oe, transfer_ack_n_o, transfer_ack_n_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_idle_quiet: assert property (sel_n [*5] |-> !transfer_ack_n_oe && !host_data_oe)
        else $error("port driven while deselected");
    a_ack_low: assert property (transfer_ack_n_oe |-> !transfer_ack_n_o)
        else $error("ack driven high");
    a_data_ack: assert property (host_data_oe |-> transfer_ack_n_oe && host_data_o == reg_rd_probe)
        else $error("read data without ack or wrong");
    a_wr_ack: assert property (!sel_n && rd_strobe_n == bus_style_select && $fell(wr_strobe_n)
        |-> ##[1:9] transfer_ack_n_oe && !host_data_oe) else $error("write ack late");
    a_rd_time: assert property (!sel_n && bus_style_select && wr_strobe_n && $fell(rd_strobe_n)
        |-> ##[1:9] host_data_oe) else $error("read data late");
    a_ds_rd_time: assert property (!sel_n && !bus_style_select && rd_strobe_n && $fell(wr_strobe_n)
        |-> ##[1:9] host_data_oe) else $error("strobe read data late");
    a_rd_release: assert property (bus_style_select && $rose(rd_strobe_n) |-> ##[1:4] !host_data_oe
        && !transfer_ack_n_oe) else $error("read not released");
    a_ds_release: assert property (!bus_style_select && $rose(wr_strobe_n) |-> ##[1:4] !host_data_oe
        && !transfer_ack_n_oe) else $error("strobe not released");
endmodule // dmhp_port_asserts
bind dmhp_port dmhp_port_asserts u_chk (.clk_sys, .rst, .bus_style_select, .sel_n, .wr_strobe_n,
    .rd_strobe_n, .host_data_o, .reg_rd_probe, .host_data_oe, .transfer_ack_n_o, .transfer_ack_n_oe);

// >>> test/dmhp_host.sv
`timescale 1ns/100ps
module dmhp_host (
    input logic clk_sys, style, ack_w, host_data_oe,
    input logic [7:0] host_data_o,
    output logic sel_n = 1'b1, wr_strobe_n = 1'b1, rd_strobe_n = 1'b1,
    output logic [5:0] reg_addr = 6'h00,
    output logic [7:0] host_data_i = 8'h00
);
    task acc(input bit s, wr, input logic [5:0] a, input logic [7:0] d, input bit hs,
        output logic [7:0] q);
        int n;
        @(posedge clk_sys);
        reg_addr <= a;
        sel_n <= !s;
        rd_strobe_n <= style | !wr;
        @(posedge clk_sys);
        if (style && !wr) rd_strobe_n <= 1'b0;
        else wr_strobe_n <= 1'b0;
        // without handshake the strobe is held past 120 ns
        for (n = 0; n < 13; n++) begin
            @(negedge clk_sys);
            if (hs && !ack_w) break;
        end
        @(posedge clk_sys);
        host_data_i <= wr ? d : ~d;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        q = host_data_oe ? host_data_o : ~d;
        @(posedge clk_sys);
        wr_strobe_n <= 1'b1;
        rd_strobe_n <= 1'b1;
        sel_n <= 1'b1;
        @(posedge clk_sys);
        host_data_i <= ~d;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule // dmhp_host

// >>> test/dmhp_port_tb_top.sv
`timescale 1ns/100ps
module dmhp_port_tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, style = 1'b1;
    logic sel_n, wr_strobe_n, rd_strobe_n, host_data_oe, transfer_ack_n_o, transfer_ack_n_oe;
    logic [5:0] reg_addr;
    logic [7:0] host_data_i, host_data_o, reg_rd_probe, q;
    int err_count = 0, samples_checked = 0;
    // undriven ack pin reads as idle
    wire ack_w = transfer_ack_n_oe ? transfer_ack_n_o : 1'b1;
    dmhp_port u_dmhp_port (.clk_sys, .rst, .bus_style_select(style), .sel_n, .reg_addr,
        .wr_strobe_n, .rd_strobe_n, .host_data_i, .host_data_o, .host_data_oe,
        .transfer_ack_n_o, .transfer_ack_n_oe, .reg_rd_probe);
    dmhp_host u_dmhp_host (.clk_sys, .style, .ack_w, .host_data_oe, .host_data_o, .sel_n,
        .wr_strobe_n, .rd_strobe_n, .reg_addr, .host_data_i);
    initial forever #5 clk_sys = ~clk_sys;
    task chk(input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task do_reset(input logic s);
        rst <= 1'b1;
        style <= s;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task t_sep;
        u_dmhp_host.acc(1, 1, 6'h3f, 8'ha5, 1, q);
        u_dmhp_host.acc(1, 1, 6'h00, 8'h5a, 0, q);
        u_dmhp_host.acc(1, 0, 6'h3f, 8'h00, 1, q);
        chk(q, 8'ha5);
        u_dmhp_host.acc(1, 0, 6'h00, 8'h00, 0, q);
        chk(q, 8'h5a);
    endtask
    task t_desel;
        u_dmhp_host.acc(0, 1, 6'h3f, 8'h3c, 1, q);
        u_dmhp_host.acc(1, 0, 6'h3f, 8'h00, 1, q);
        chk(q, 8'ha5);
    endtask
    task t_ds;
        do_reset(1'b0);
        u_dmhp_host.acc(1, 0, 6'h3f, 8'h00, 1, q);
        chk(q, 8'h00);
        u_dmhp_host.acc(1, 1, 6'h21, 8'h81, 1, q);
        u_dmhp_host.acc(1, 1, 6'h22, 8'h7e, 0, q);
        u_dmhp_host.acc(1, 0, 6'h21, 8'h00, 1, q);
        chk(q, 8'h81);
        u_dmhp_host.acc(1, 0, 6'h22, 8'h00, 0, q);
        chk(q, 8'h7e);
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        do_reset(1'b1);
        t_sep;
        t_desel;
        t_ds;
        end_of_test;
    end
    initial begin
        #20000;
        err_count++;
        end_of_test;
    end
endmodule // dmhp_port_tb_top
